/* verilog/pulse_accum_pkg.sv */
package pulse_accum_pkg;

  // Register indices; each register is one aligned word at four times its index
  localparam logic [7:0] OFF_A_CONTROL = 8'h20;
  localparam logic [7:0] OFF_A_FLAGS = 8'h21;
  localparam logic [7:0] OFF_COUNT3 = 8'h22;
  localparam logic [7:0] OFF_COUNT2 = 8'h23;
  localparam logic [7:0] OFF_COUNT1 = 8'h24;
  localparam logic [7:0] OFF_COUNT0 = 8'h25;
  localparam logic [7:0] OFF_MOD_CONTROL = 8'h26;
  // Extra registers for loose control bits, the modulus count and the status flags
  localparam logic [7:0] OFF_AUX_CONTROL = 8'h38;
  localparam logic [7:0] OFF_MOD_COUNT = 8'h39;
  localparam logic [7:0] OFF_STATUS = 8'h3A;

  // Field positions of the A control register
  localparam int A_SYS_ON_BIT = 6;
  localparam int A_MODE_BIT = 5;
  localparam int A_EDGE_BIT = 4;
  localparam int A_CLK_HI_BIT = 3;
  localparam int A_CLK_LO_BIT = 2;
  localparam int A_WRAP_IE_BIT = 1;
  localparam int A_INPUT_IE_BIT = 0;
  // Flag register fields
  localparam int FLAG_WRAP_BIT = 1;
  localparam int FLAG_EDGE_BIT = 0;
  // Modulus control fields
  localparam int MC_IRQ_EN_BIT = 7;
  localparam int MC_RELOAD_BIT = 6;
  localparam int MC_READ_LOAD_BIT = 5;
  localparam int MC_LATCH_BIT = 4;
  localparam int MC_FORCE_LOAD_BIT = 3;
  localparam int MC_ON_BIT = 2;
  // Auxiliary control fields
  localparam int AUX_TIMER_ON_BIT = 0;
  localparam int AUX_FAST_CLR_BIT = 1;
  localparam int AUX_SATURATE_BIT = 2;
  localparam int AUX_BUF_ON_BIT = 3;
  localparam int AUX_LATCH_OR_QUEUE_SEL_BIT = 4;
  localparam int AUX_ACC3_ON_BIT = 5;
  localparam int AUX_ACC2_ON_BIT = 6;
  localparam int AUX_B_ON_BIT = 7;

  // Values after reset and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] MOD_PRESET = 16'hFFFF;
  localparam int GATE_DIVIDE = 64;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Counter clock select codes
  typedef enum logic [1:0] {
    CLK_PRESCALER = 2'b00,
    CLK_ACCUM = 2'b01,
    CLK_ACCUM_256 = 2'b10,
    CLK_ACCUM_65536 = 2'b11
  } clock_sel_t;

  // Pin group toward the timer
  typedef struct packed {
    logic timer_pin_7;
    logic timer_pin_3;
    logic timer_pin_0;
    logic prescaler_tick;
  } pin_in_t;

  // Request outputs
  typedef struct packed {
    logic accum_a_wrap_irq;
    logic accum_input_irq;
    logic mod_underflow_irq;
    logic counter_clock_tick;
    logic capture_latch;
  } event_out_t;

endpackage

/* verilog/pulse_accumulator_modulus_counter.sv */
`timescale 1ns/1ps
module pulse_accumulator_modulus_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pulse_accum_pkg::pin_in_t pins,
  output pulse_accum_pkg::event_out_t events
);
  import pulse_accum_pkg::*;

  // Control registers
  logic [7:0] a_control;
  logic [7:0] aux_control;
  logic [7:0] mod_control;
  logic wrap_a_flag;
  logic edge_flag;
  logic wrap_b_flag;
  logic [7:0] acc3, acc2, acc1, acc0;
  logic [15:0] mod_count;
  logic [15:0] mod_load;
  logic [1:0] active_prescale;
  logic [3:0] mod_prescale_cnt;
  logic mod_zero_flag;
  // Pin history for edge detection
  logic pin7_q, pin3_q, pin0_q;
  logic [5:0] gate_div;
  logic [15:0] tick_div;

  // Write channel capture
  logic [7:0] aw_addr;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] ar_idx; // Word index of the read address

  // Decoded enables
  logic a_on, b_on, gated, edge_sel, timer_on, saturate;
  logic fast_clr;
  assign a_on = a_control[A_SYS_ON_BIT];
  assign b_on = aux_control[AUX_B_ON_BIT];
  assign gated = a_control[A_MODE_BIT];
  assign edge_sel = a_control[A_EDGE_BIT];
  assign timer_on = aux_control[AUX_TIMER_ON_BIT];
  assign saturate = aux_control[AUX_SATURATE_BIT];
  assign fast_clr = aux_control[AUX_FAST_CLR_BIT];

  // Pin 7, pin 3 and pin 0 edges and the gated div64 tick
  logic rise7, fall7, rise3, fall3, rise0, fall0;
  logic div64_tick, count_a_tick, trail_edge;
  assign rise7 = pins.timer_pin_7 & ~pin7_q;
  assign fall7 = ~pins.timer_pin_7 & pin7_q;
  assign rise3 = pins.timer_pin_3 & ~pin3_q;
  assign fall3 = ~pins.timer_pin_3 & pin3_q;
  assign rise0 = pins.timer_pin_0 & ~pin0_q;
  assign fall0 = ~pins.timer_pin_0 & pin0_q;
  assign div64_tick = timer_on && pins.prescaler_tick &&
                      (gate_div == 6'(GATE_DIVIDE - 1));
  assign count_a_tick = gated ?
    (div64_tick && (pins.timer_pin_7 ^ edge_sel)) :
    (edge_sel ? rise7 : fall7);
  assign trail_edge = edge_sel ? rise7 : fall7;

  // Byte count tick for single-byte accumulators
  logic acc3_tick, acc2_tick, acc1_tick, acc0_tick;
  assign acc3_tick = !a_on && aux_control[AUX_ACC3_ON_BIT] &&
                     rise3;
  assign acc2_tick = !a_on && aux_control[AUX_ACC2_ON_BIT] && rise3;
  assign acc1_tick = !b_on && rise0;
  assign acc0_tick = b_on ? rise0 : 1'b0;

  // Increment with optional saturation
  function automatic logic [7:0] bump(input logic [7:0] v, input logic sat);
    if (sat && v == 8'hFF) begin
      return v;
    end
    return v + 8'h01;
  endfunction

  // Word index of a byte address; a misaligned address names no register
  function automatic logic [7:0] word_index(input logic [7:0] a);
    return (a[1:0] == 2'b00) ? {2'b00, a[7:2]} : 8'hFF;
  endfunction

  // Index names one of the registers of this block
  function automatic logic is_reg(input logic [7:0] i);
    return (i >= OFF_A_CONTROL && i <= OFF_MOD_CONTROL) || i == OFF_AUX_CONTROL ||
      i == OFF_MOD_COUNT || i == OFF_STATUS;
  endfunction

  // Access decoding for writes and reads
  logic wr_c3, wr_c2, wr_c1, wr_c0, rd_c3, rd_c2, acc_a_touch;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_c3 = wr_fire && aw_addr == OFF_COUNT3 && w_strb[0];
  assign wr_c2 = wr_fire && aw_addr == OFF_COUNT2 && w_strb[0];
  assign wr_c1 = wr_fire && aw_addr == OFF_COUNT1 && w_strb[0];
  assign wr_c0 = wr_fire && aw_addr == OFF_COUNT0 && w_strb[0];
  assign ar_idx = word_index(s_axi_araddr);
  assign rd_c3 = rd_fire && ar_idx == OFF_COUNT3;
  assign rd_c2 = rd_fire && ar_idx == OFF_COUNT2;
  assign acc_a_touch = fast_clr && (wr_c3 || wr_c2 || rd_c3 || rd_c2);

  // Latch mode and force latch
  logic latch_now;
  assign latch_now = wr_fire && aw_addr == OFF_MOD_CONTROL && w_strb[0] &&
    w_data[MC_LATCH_BIT] && aux_control[AUX_BUF_ON_BIT] &&
    aux_control[AUX_LATCH_OR_QUEUE_SEL_BIT];

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= word_index(s_axi_awaddr); // Misaligned lands nowhere
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_reg(aw_addr) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready levels from registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= AXI_OKAY;
        if (ar_idx == OFF_A_CONTROL) begin
          s_axi_rdata <= {24'h000000, a_control};
        end else if (ar_idx == OFF_A_FLAGS) begin
          s_axi_rdata <= {30'h0, wrap_a_flag, edge_flag};
        end else if (ar_idx == OFF_COUNT3) begin
          s_axi_rdata <= {24'h000000, acc3};
        end else if (ar_idx == OFF_COUNT2) begin
          s_axi_rdata <= {24'h000000, acc2};
        end else if (ar_idx == OFF_COUNT1) begin
          s_axi_rdata <= {24'h000000, acc1};
        end else if (ar_idx == OFF_COUNT0) begin
          s_axi_rdata <= {24'h000000, acc0};
        end else if (ar_idx == OFF_MOD_CONTROL) begin
          // Force bits always read zero
          s_axi_rdata <= {24'h000000, mod_control};
        end else if (ar_idx == OFF_AUX_CONTROL) begin
          s_axi_rdata <= {24'h000000, aux_control};
        end else if (ar_idx == OFF_MOD_COUNT) begin
          s_axi_rdata <= {16'h0000, mod_control[MC_READ_LOAD_BIT] ?
                          mod_load : mod_count};
        end else if (ar_idx == OFF_STATUS) begin
          s_axi_rdata <= {29'h0, wrap_b_flag, mod_zero_flag, 1'b0};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= AXI_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control registers; force bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_control <= RESET_BYTE;
      aux_control <= RESET_BYTE;
      mod_control <= RESET_BYTE;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == OFF_A_CONTROL) begin
        a_control <= {1'b0, w_data[6:0]};
      end else if (aw_addr == OFF_AUX_CONTROL) begin
        aux_control <= w_data[7:0];
      end else if (aw_addr == OFF_MOD_CONTROL) begin
        mod_control <= {w_data[7:5], 2'b00, w_data[2:0]};
      end
    end
  end

  // Input pin history and divide-by-64 from the timer prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin7_q <= 1'b0;
      pin3_q <= 1'b0;
      pin0_q <= 1'b0;
      gate_div <= 6'h00;
    end else begin
      pin7_q <= pins.timer_pin_7;
      pin3_q <= pins.timer_pin_3;
      pin0_q <= pins.timer_pin_0;
      if (!timer_on) begin
        gate_div <= 6'h00;
      end else if (pins.prescaler_tick) begin
        gate_div <= gate_div + 6'h01;
      end
    end
  end

  // Accumulators 3 and 2: cascaded or single, writes win over ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc3 <= RESET_BYTE;
      acc2 <= RESET_BYTE;
    end else if (latch_now) begin
      acc3 <= RESET_BYTE;
      acc2 <= RESET_BYTE;
    end else begin
      if (wr_c3) begin
        acc3 <= w_data[7:0];
      end else if (a_on && count_a_tick && acc2 == 8'hFF && !wr_c2) begin
        acc3 <= acc3 + 8'h01;
      end else if (acc3_tick) begin
        acc3 <= bump(acc3, saturate);
      end
      if (wr_c2) begin
        acc2 <= w_data[7:0];
      end else if (a_on && count_a_tick) begin
        acc2 <= acc2 + 8'h01;
      end else if (acc2_tick) begin
        acc2 <= bump(acc2, saturate);
      end
    end
  end

  // Accumulators 1 and 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc1 <= RESET_BYTE;
      acc0 <= RESET_BYTE;
    end else if (latch_now) begin
      acc1 <= RESET_BYTE;
      acc0 <= RESET_BYTE;
    end else begin
      if (wr_c1) begin
        acc1 <= w_data[7:0];
      end else if (b_on && acc0_tick && acc0 == 8'hFF && !wr_c0) begin
        acc1 <= acc1 + 8'h01;
      end else if (acc1_tick) begin
        acc1 <= bump(acc1, saturate);
      end
      if (wr_c0) begin
        acc0 <= w_data[7:0];
      end else if (acc0_tick) begin
        acc0 <= acc0 + 8'h01;
      end
    end
  end

  // Flags: hardware set wins over software clear
  logic set_wrap_a, set_edge, set_wrap_b, clr_wrap_a, clr_edge;
  // A counted edge at FF sets the flag whether byte 3 wraps or saturates
  assign set_wrap_a = !latch_now && !wr_c3 && acc3 == 8'hFF &&
    ((a_on && count_a_tick && acc2 == 8'hFF && !wr_c2) || acc3_tick);
  assign set_edge = a_on && trail_edge;
  assign set_wrap_b = !latch_now && !wr_c1 && acc1 == 8'hFF &&
    ((b_on && acc0_tick && acc0 == 8'hFF && !wr_c0) ||
     (acc1_tick && !saturate));
  assign clr_wrap_a = acc_a_touch || (wr_fire && aw_addr == OFF_A_FLAGS &&
    w_strb[0] && w_data[FLAG_WRAP_BIT]);
  assign clr_edge = acc_a_touch || (wr_fire && aw_addr == OFF_A_FLAGS &&
    w_strb[0] && w_data[FLAG_EDGE_BIT]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_a_flag <= 1'b0;
      edge_flag <= 1'b0;
      wrap_b_flag <= 1'b0;
    end else begin
      wrap_a_flag <= set_wrap_a | (wrap_a_flag & ~clr_wrap_a);
      edge_flag <= set_edge | (edge_flag & ~clr_edge);
      wrap_b_flag <= set_wrap_b | (wrap_b_flag & ~(wr_fire &&
        aw_addr == OFF_STATUS && w_strb[0] && w_data[2]));
    end
  end

  // Modulus down-counter with prescaler
  logic mod_on, force_load, mod_tick, load_write;
  logic [3:0] prescale_top;
  assign mod_on = mod_control[MC_ON_BIT];
  assign force_load = mod_on && wr_fire && aw_addr == OFF_MOD_CONTROL &&
                      w_strb[0] && w_data[MC_FORCE_LOAD_BIT];
  assign load_write = wr_fire && aw_addr == OFF_MOD_COUNT && (w_strb[1:0] != 2'b00);
  assign prescale_top = (active_prescale == 2'b00) ? 4'h0 :
    (active_prescale == 2'b01) ? 4'h3 : (active_prescale == 2'b10) ? 4'h7 : 4'hF;
  assign mod_tick = mod_prescale_cnt == prescale_top;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_count <= MOD_PRESET;
      mod_load <= 16'h0000;
      active_prescale <= 2'b00;
      mod_prescale_cnt <= 4'h0;
      mod_zero_flag <= 1'b0;
    end else begin
      if (load_write) begin
        mod_load <= w_data[15:0];
      end
      if (!mod_on) begin
        mod_count <= MOD_PRESET;
        mod_prescale_cnt <= 4'h0;
      end else if (force_load || load_write) begin
        mod_count <= load_write ? w_data[15:0] : mod_load;
        active_prescale <= mod_control[1:0];
        mod_prescale_cnt <= 4'h0;
      end else if (mod_count != 16'h0000) begin
        mod_prescale_cnt <= mod_tick ? 4'h0 : mod_prescale_cnt + 4'h1;
        if (mod_tick) begin
          mod_count <= mod_count - 16'h0001;
          if (mod_count == 16'h0001) begin
            mod_zero_flag <= 1'b1;
          end
        end
      end else if (mod_control[MC_RELOAD_BIT]) begin
        mod_count <= mod_load;
        active_prescale <= mod_control[1:0];
      end
      if (wr_fire && aw_addr == OFF_STATUS && w_strb[0] && w_data[1] &&
          !(mod_on && mod_tick && mod_count == 16'h0001)) begin
        mod_zero_flag <= 1'b0;
      end
    end
  end

  // Clock select and event outputs, all registered
  logic pick_tick;
  always_comb begin
    pick_tick = pins.prescaler_tick;
    if (a_on) begin
      case (clock_sel_t'(a_control[A_CLK_HI_BIT:A_CLK_LO_BIT]))
        CLK_PRESCALER: pick_tick = pins.prescaler_tick;
        CLK_ACCUM: pick_tick = count_a_tick;
        CLK_ACCUM_256: pick_tick = count_a_tick && tick_div[7:0] == 8'hFF;
        CLK_ACCUM_65536: pick_tick = count_a_tick && tick_div == 16'hFFFF;
        default: pick_tick = pins.prescaler_tick;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_div <= 16'h0000;
      events <= '0;
    end else begin
      if (a_on && count_a_tick) begin
        tick_div <= tick_div + 16'h0001;
      end
      events.accum_a_wrap_irq <= wrap_a_flag && a_control[A_WRAP_IE_BIT];
      events.accum_input_irq <= edge_flag && a_control[A_INPUT_IE_BIT];
      events.mod_underflow_irq <= mod_zero_flag && mod_control[MC_IRQ_EN_BIT];
      events.counter_clock_tick <= pick_tick;
      events.capture_latch <= latch_now;
    end
  end

endmodule // pulse_accumulator_modulus_counter

/* testbench/pulse_accum_chk.sv */
`timescale 1ns/1ps
module pulse_accum_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire pulse_accum_pkg::event_out_t events
);
  import pulse_accum_pkg::*;
  logic [7:0] ar_q; // Word index of the read under way
  logic is_map; // Read address names a register
  // Remember the read address when it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= (s_axi_araddr[1:0] == 2'b00) ? {2'b00, s_axi_araddr[7:2]} : 8'hFF;
    end
  end
  assign is_map = ar_q inside {[OFF_A_CONTROL:OFF_MOD_CONTROL], OFF_AUX_CONTROL,
    OFF_MOD_COUNT, OFF_STATUS};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Quiet outputs right after reset
  property p_reset_quiet;
    $rose(aresetn) |-> events == '0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  // Read answer one cycle after address taken
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  // Answers end once taken
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  // Unmapped reads refused with zero data
  property p_unmapped;
    s_axi_rvalid && !is_map |-> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // Mapped reads succeed and stay within 16 bits
  property p_mapped;
    s_axi_rvalid && is_map |-> s_axi_rresp == AXI_OKAY && s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read wrong form");
  // Flag register has two bits only
  property p_flag_bits;
    s_axi_rvalid && ar_q == OFF_A_FLAGS |-> s_axi_rdata[31:2] == 30'h0;
  endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("flag read has extra bits");
  // Strobe bits always read zero
  property p_strobe_zero;
    s_axi_rvalid && ar_q == OFF_MOD_CONTROL |->
      !s_axi_rdata[MC_LATCH_BIT] && !s_axi_rdata[MC_FORCE_LOAD_BIT];
  endproperty
  a_strobe_zero: assert property (p_strobe_zero) else $error("strobe bit read one");
  // Latch pulse lasts one cycle
  property p_latch_pulse;
    events.capture_latch |=> !events.capture_latch;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("latch pulse too long");
endmodule // pulse_accum_chk

/* testbench/pulse_pin_model.sv */
`timescale 1ns/1ps
module pulse_pin_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] lv,
  output pulse_accum_pkg::pin_in_t pins
);
  import pulse_accum_pkg::*;
  int cnt; // Prescaler stand-in count
  // Timer prescaler ticks and pin levels as the bench commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      pins <= '0;
    end else begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      pins.prescaler_tick <= (cnt == TICK_DIV - 1);
      pins.timer_pin_7 <= lv[2];
      pins.timer_pin_3 <= lv[1];
      pins.timer_pin_0 <= lv[0];
    end
  end
endmodule // pulse_pin_model

/* testbench/pulse_accumulator_modulus_counter_tb.sv */
`timescale 1ns/1ps
module pulse_accumulator_modulus_counter_tb;
  import pulse_accum_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, t;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [2:0] lv = 3'b000; // Pin 7, pin 3, pin 0 levels
  logic [3:0] wstrb = 4'hF; // Write byte lanes
  pin_in_t pins;
  event_out_t events;
  int failures = 0, n_tests = 0, n_clk = 0, n_lat = 0;
  logic [7:0] offs [9] = '{OFF_A_CONTROL, OFF_A_FLAGS, OFF_COUNT3, OFF_COUNT2, OFF_COUNT1,
    OFF_COUNT0, OFF_MOD_CONTROL, OFF_AUX_CONTROL, OFF_STATUS};
  always #2 aclk = ~aclk;
  // Count counter clock ticks and latch pulses
  always @(posedge aclk) begin
    if (events.counter_clock_tick === 1'b1) n_clk++;
    if (events.capture_latch === 1'b1) n_lat++;
  end
  pulse_pin_model u_pulse_pin_model (.aclk(aclk), .aresetn(aresetn), .lv(lv), .pins(pins));
  pulse_accumulator_modulus_counter u_pulse_accumulator_modulus_counter (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins(pins), .events(events));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= {a[5:0], 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (k < 200) begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) k = 500;
    end
    bready <= 1'b0;
    if (k < 500) failures++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    v = 32'h0;
    rs = 2'b00;
    @(posedge aclk);
    araddr <= {a[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (k < 200) begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        k = 500;
      end
    end
    rready <= 1'b0;
    if (k < 500) failures++;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    check($sformatf("reg %h", a), v, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic set_pin(input int b, input logic v);
    @(posedge aclk);
    lv[b] <= v;
    wt(4);
  endtask
  task automatic pulse(input int b);
    set_pin(b, 1'b1);
    set_pin(b, 1'b0);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    wt(4);
    aresetn <= 1'b1;
    wt(1);
    for (int i = 0; i < 9; i++) rc(offs[i], 32'h0);
    rc(OFF_MOD_COUNT, 32'h0000FFFF);
    rd(8'h30, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, AXI_SLVERR});
    check("unmapped data", d, 32'h0);
    // Event counting across the 16-bit wrap
    wr(OFF_A_CONTROL, 32'h43);
    wr(OFF_COUNT3, 32'hFF);
    wr(OFF_COUNT2, 32'hFE);
    pulse(2);
    pulse(2);
    rc(OFF_COUNT3, 32'h0);
    rc(OFF_COUNT2, 32'h0);
    rc(OFF_A_FLAGS, 32'h3);
    check("irqs", {30'h0, events.accum_a_wrap_irq, events.accum_input_irq}, 32'h3);
    wr(OFF_A_FLAGS, 32'h2);
    rc(OFF_A_FLAGS, 32'h1);
    wr(OFF_A_CONTROL, 32'h40);
    wt(3);
    check("irqs off", {30'h0, events.accum_a_wrap_irq, events.accum_input_irq}, 32'h0);
    // Rising edge counts, falling does not
    wr(OFF_A_CONTROL, 32'h50);
    wr(OFF_COUNT2, 32'h0);
    set_pin(2, 1'b1);
    rc(OFF_COUNT2, 32'h1);
    set_pin(2, 1'b0);
    rc(OFF_COUNT2, 32'h1);
    wr(OFF_AUX_CONTROL, 32'h02);
    rd(OFF_COUNT3, d, r);
    rc(OFF_A_FLAGS, 32'h0);
    wr(OFF_AUX_CONTROL, 32'h0);
    wr(OFF_A_CONTROL, 32'h0);
    pulse(2);
    rc(OFF_A_FLAGS, 32'h0);
    rc(OFF_COUNT2, 32'h1);
    // Gated accumulation with timer on, then off
    wr(OFF_AUX_CONTROL, 32'h01);
    wr(OFF_A_CONTROL, 32'h60);
    set_pin(2, 1'b1);
    wt(1100);
    set_pin(2, 1'b0);
    rd(OFF_COUNT2, d, r);
    check("gated count", {31'h0, d > 32'h1}, 32'h1);
    rc(OFF_A_FLAGS, 32'h1);
    wr(OFF_AUX_CONTROL, 32'h0);
    pulse(2);
    set_pin(2, 1'b1);
    wt(1100);
    set_pin(2, 1'b0);
    rc(OFF_COUNT2, d);
    // Counter clock from accumulator, then prescaler
    wr(OFF_A_CONTROL, 32'h44);
    wt(2);
    t = n_clk;
    repeat (3) pulse(2);
    check("accum ticks", n_clk - t, 32'h3);
    wr(OFF_A_CONTROL, 32'h04);
    t = n_clk;
    wt(40);
    check("presc ticks", {31'h0, (n_clk - t) > 5}, 32'h1);
    // Byte 3 saturate and wrap
    wr(OFF_A_CONTROL, 32'h0);
    wr(OFF_A_FLAGS, 32'h3);
    wr(OFF_AUX_CONTROL, 32'h24);
    wr(OFF_COUNT3, 32'hFF);
    pulse(1);
    rc(OFF_COUNT3, 32'hFF);
    rc(OFF_A_FLAGS, 32'h2);
    wr(OFF_A_FLAGS, 32'h3);
    wr(OFF_AUX_CONTROL, 32'h20);
    pulse(1);
    rc(OFF_COUNT3, 32'h0);
    rc(OFF_A_FLAGS, 32'h2);
    // Accumulator B wrap
    wr(OFF_AUX_CONTROL, 32'h80);
    wr(OFF_COUNT1, 32'hFF);
    wr(OFF_COUNT0, 32'hFF);
    pulse(0);
    rc(OFF_COUNT1, 32'h0);
    rc(OFF_COUNT0, 32'h0);
    rc(OFF_STATUS, 32'h4);
    // Modulus one-shot, read select, force load, disable
    wr(OFF_STATUS, 32'h6);
    wr(OFF_MOD_CONTROL, 32'h04);
    wr(OFF_MOD_COUNT, 32'h5);
    wt(40);
    rc(OFF_MOD_COUNT, 32'h0);
    rc(OFF_STATUS, 32'h2);
    wr(OFF_MOD_CONTROL, 32'hA4);
    wt(3);
    check("mod irq", {31'h0, events.mod_underflow_irq}, 32'h1);
    rc(OFF_MOD_COUNT, 32'h5);
    wr(OFF_MOD_CONTROL, 32'hAC);
    rc(OFF_MOD_CONTROL, 32'hA4);
    wr(OFF_MOD_CONTROL, 32'h0);
    wt(3);
    check("mod irq off", {31'h0, events.mod_underflow_irq}, 32'h0);
    rc(OFF_MOD_COUNT, 32'hFFFF);
    wr(OFF_MOD_CONTROL, 32'h07);
    wr(OFF_MOD_COUNT, 32'h10);
    wt(40);
    rd(OFF_MOD_COUNT, d, r);
    check("slow count", {31'h0, d != 32'h0}, 32'h1);
    wr(OFF_MOD_CONTROL, 32'h0);
    // Reload mode underflows again after the flag is cleared
    wr(OFF_MOD_CONTROL, 32'h44);
    wr(OFF_MOD_COUNT, 32'h8);
    wt(20);
    wr(OFF_STATUS, 32'h2);
    wt(20);
    rc(OFF_STATUS, 32'h2);
    wr(OFF_MOD_CONTROL, 32'h0);
    // Force latch with and without buffering
    wr(OFF_AUX_CONTROL, 32'h58);
    wr(OFF_COUNT2, 32'h7);
    t = n_lat;
    wr(OFF_MOD_CONTROL, 32'h10);
    wt(3);
    check("latch", n_lat - t, 32'h1);
    rc(OFF_COUNT2, 32'h0);
    rc(OFF_MOD_CONTROL, 32'h0);
    wr(OFF_AUX_CONTROL, 32'h40);
    wr(OFF_COUNT2, 32'h7);
    t = n_lat;
    wr(OFF_MOD_CONTROL, 32'h10);
    wt(3);
    check("no latch", n_lat - t, 32'h0);
    rc(OFF_COUNT2, 32'h7);
    // A write with the low lane off leaves the byte alone
    wstrb <= 4'h0;
    wr(OFF_COUNT2, 32'h55);
    wstrb <= 4'hF;
    rc(OFF_COUNT2, 32'h7);
    wrap_up();
  end
endmodule // pulse_accumulator_modulus_counter_tb
bind pulse_accumulator_modulus_counter pulse_accum_chk u_pulse_accum_chk (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .events);
